// [design/ihbc_bus_cycles.sv]
`timescale 1ns/1ps
// Operation
// - Acknowledge is two back-to-back bus cycles with nothing between.
// - Atomic output asserted across both acknowledge cycles.
// - Acknowledge uses read timing, pulsing the acknowledge strobe, not read.
// - Vector captured from data bits 7:0 in second cycle only.
// - Cascade mode with control block at zero ignores ready, no waits.
// - Latch strobe pulses in both cycles; only top nibble driven then.
// - Halt instruction makes bus interface run one halt cycle.
// - After halt, wait for interrupt, hold, DMA or refresh request.
// - Powerdown mode lets only interrupts release the halt.
// - Halt first state floats bus unless it follows a write.
// - Top nibble keeps previous value, or next prefetch address.
// - Halt cycle behaviour repeats for the same preceding sequence.
// - Programmed chip-selects held inactive during a halt cycle.
// - Idle or powerdown: after idle states drive buses low, controls inactive.
// - Plain halt: data floats, top nibble 8H or zero, byte-high held.
// - In halt, read, write, transceiver, refresh and status lines high.
// - Hold, DMA or refresh leaves halt temporarily, then returns.
// - Return to halt reruns no halt cycle, no strobe, no status.
// - Any interrupt ends halt; first operations reload code segment and pointer.
// - Transceiver direction low during acknowledge cycles.
module ihbc_bus_cycles
	import ihbc_pkg::*;
#(
	parameter int unsigned IDLE_STATES = IDLE_T_STATES
)
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_ack_req,
	input  wire logic        i_halt_instr,
	input  wire logic        i_after_write,
	input  wire logic        i_use_prefetch,
	input  wire logic [3:0]  i_prefetch_upper,
	input  wire logic [15:0] i_write_value,
	input  wire logic        i_cascade_mode,
	input  wire logic [15:0] i_periph_ctrl_block_base,
	input  wire logic        i_idle_mode,
	input  wire logic        i_powerdown_mode,
	input  wire logic        i_ready,
	input  wire logic        i_irq,
	input  wire logic        i_hold_req,
	input  wire logic        i_dma_req,
	input  wire logic        i_refresh_req,
	input  wire logic        i_away_done,
	input  wire logic [15:0] i_muxed_addr_data,
	output logic [15:0]      o_muxed_addr_data,
	output logic             o_muxed_addr_data_oe_n,
	output logic [3:0]       o_upper_addr_status,
	output logic             o_upper_byte_en_n,
	output logic             o_addr_latch,
	output logic             o_irq_ack_strobe_n,
	output logic             o_rd_n,
	output logic             o_wr_n,
	output logic             o_xcvr_output_en_n,
	output logic             o_xcvr_direction,
	output logic             o_refresh_flag_n,
	output logic [2:0]       o_cycle_status,
	output logic             o_atomic_n,
	output logic             o_chip_sel_block,
	output logic             o_vector_valid,
	output logic [7:0]       o_vector,
	output logic             o_halted,
	output logic             o_away_grant,
	output logic             o_reload_req
);

	// ****************************************************************
	// Sequencer state
	// ****************************************************************
	ihbc_state_t state_reg;
	logic        second_reg;
	logic        is_halt_reg;
	logic [2:0]  idle_cnt_reg;
	logic        irq_s1_reg, irq_s2_reg;
	logic        rdy_s1_reg, rdy_s2_reg;
	logic        hold_s1_reg, hold_s2_reg;
	logic        dma_s1_reg, dma_s2_reg;
	logic        refresh_flag_n_s1_reg, refresh_flag_n_s2_reg;
	logic [15:0] bus_s1_reg, bus_s2_reg;
	logic [1:0]  cap_pipe_reg;

	logic ready_ok;
	logic away_req;
	logic low_power;
	logic quiet;

	// Control block at zero in cascade mode makes ready irrelevant
	// ready bypass
	assign ready_ok = rdy_s2_reg | (i_cascade_mode &&
		(i_periph_ctrl_block_base == PCB_BASE_ZERO));
	// Powerdown blocks temporary exits
	// powerdown gating
	assign away_req = (hold_s2_reg | dma_s2_reg | refresh_flag_n_s2_reg) & ~i_powerdown_mode;
	assign low_power = i_idle_mode | i_powerdown_mode;
	assign quiet = low_power && (idle_cnt_reg >= IDLE_CNT_W_MAX);

	// Two-flop synchronisers for pin inputs
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			irq_s1_reg  <= 1'b0;
			irq_s2_reg  <= 1'b0;
			rdy_s1_reg  <= 1'b0;
			rdy_s2_reg  <= 1'b0;
			hold_s1_reg <= 1'b0;
			hold_s2_reg <= 1'b0;
			dma_s1_reg  <= 1'b0;
			dma_s2_reg  <= 1'b0;
			refresh_flag_n_s1_reg <= 1'b0;
			refresh_flag_n_s2_reg <= 1'b0;
			bus_s1_reg  <= 16'h0000;
			bus_s2_reg  <= 16'h0000;
		end
		else
		begin
			irq_s1_reg  <= i_irq;
			irq_s2_reg  <= irq_s1_reg;
			rdy_s1_reg  <= i_ready;
			rdy_s2_reg  <= rdy_s1_reg;
			hold_s1_reg <= i_hold_req;
			hold_s2_reg <= hold_s1_reg;
			dma_s1_reg  <= i_dma_req;
			dma_s2_reg  <= dma_s1_reg;
			refresh_flag_n_s1_reg <= i_refresh_req;
			refresh_flag_n_s2_reg <= refresh_flag_n_s1_reg;
			bus_s1_reg  <= i_muxed_addr_data;
			bus_s2_reg  <= bus_s1_reg;
		end
	end

	// ****************************************************************
	// Cycle sequencer
	// ****************************************************************
	// Acknowledge pair runs back to back; halt takes one cycle only
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state_reg   <= IHBC_ST_IDLE;
			second_reg  <= 1'b0;
			is_halt_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				IHBC_ST_IDLE:
				begin
					if (i_ack_req)
					begin
						state_reg   <= IHBC_ST_T1;
						is_halt_reg <= 1'b0;
						second_reg  <= 1'b0;
					end
					else if (i_halt_instr)
					begin
						state_reg   <= IHBC_ST_T1;
						is_halt_reg <= 1'b1;
					end
				end
				IHBC_ST_T1: state_reg <= IHBC_ST_T2;
				IHBC_ST_T2: state_reg <= IHBC_ST_T3;
				IHBC_ST_T3, IHBC_ST_TW:
				begin
					if (is_halt_reg || ready_ok)
						state_reg <= IHBC_ST_T4;
					else
						state_reg <= IHBC_ST_TW;
				end
				IHBC_ST_T4:
				begin
					if (is_halt_reg)
						state_reg <= IHBC_ST_HALT;
					else if (!second_reg)
					begin
						state_reg  <= IHBC_ST_T1;
						second_reg <= 1'b1;
					end
					else
					begin
						state_reg  <= IHBC_ST_IDLE;
						second_reg <= 1'b0;
					end
				end
				IHBC_ST_HALT:
				begin
					if (irq_s2_reg)
						state_reg <= IHBC_ST_IDLE;
					else if (away_req)
						state_reg <= IHBC_ST_AWAY;
				end
				IHBC_ST_AWAY:
				begin
					if (i_away_done)
						state_reg <= IHBC_ST_HALT;
				end
				default: state_reg <= IHBC_ST_IDLE;
			endcase
		end
	end

	// Idle bus state counter, saturates at the quiet threshold
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			idle_cnt_reg <= 3'h0;
		else if (state_reg != IHBC_ST_HALT)
			idle_cnt_reg <= 3'h0;
		else if (idle_cnt_reg < IDLE_CNT_W_MAX)
			idle_cnt_reg <= idle_cnt_reg + 3'h1;
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	// Outputs registered from current state; one-cycle lag is accepted
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_muxed_addr_data      <= 16'h0000;
			o_muxed_addr_data_oe_n <= 1'b1;
			o_upper_addr_status    <= UPPER_ZERO;
			o_upper_byte_en_n      <= 1'b1;
			o_addr_latch           <= 1'b0;
			o_irq_ack_strobe_n     <= 1'b1;
			o_rd_n                 <= 1'b1;
			o_wr_n                 <= 1'b1;
			o_xcvr_output_en_n     <= 1'b1;
			o_xcvr_direction       <= 1'b1;
			o_refresh_flag_n       <= 1'b1;
			o_cycle_status         <= CST_PASSIVE;
			o_atomic_n             <= 1'b1;
			o_chip_sel_block       <= 1'b0;
		end
		else
		begin
			o_rd_n             <= 1'b1;
			o_wr_n             <= 1'b1;
			o_refresh_flag_n   <= 1'b1;
			o_xcvr_output_en_n <= 1'b1;
			o_xcvr_direction   <= 1'b1;
			o_cycle_status     <= CST_PASSIVE;
			o_addr_latch       <= 1'b0;
			o_irq_ack_strobe_n <= 1'b1;
			o_atomic_n         <= 1'b1;
			o_chip_sel_block   <= is_halt_reg && (state_reg != IHBC_ST_IDLE);
			if (!is_halt_reg && state_reg != IHBC_ST_IDLE && state_reg != IHBC_ST_HALT
				&& state_reg != IHBC_ST_AWAY)
			begin
				o_atomic_n         <= 1'b0;
				o_xcvr_direction   <= 1'b0;
				o_muxed_addr_data_oe_n <= 1'b1;
				o_addr_latch       <= (state_reg == IHBC_ST_T1);
				o_cycle_status     <= (state_reg == IHBC_ST_T1) ? CST_INTACK : CST_PASSIVE;
				o_irq_ack_strobe_n <= ~(state_reg == IHBC_ST_T2 || state_reg == IHBC_ST_T3
					|| state_reg == IHBC_ST_TW);
				o_xcvr_output_en_n <= (state_reg == IHBC_ST_T1);
			end
			else if (is_halt_reg && state_reg == IHBC_ST_T1)
			begin
				o_addr_latch   <= 1'b1;
				o_cycle_status <= CST_HALT;
				o_muxed_addr_data      <= i_write_value;
				o_muxed_addr_data_oe_n <= ~i_after_write;
				if (i_use_prefetch)
					o_upper_addr_status <= i_prefetch_upper;
			end
			else if (state_reg == IHBC_ST_HALT)
			begin
				if (quiet)
				begin
					o_muxed_addr_data      <= 16'h0000;
					o_muxed_addr_data_oe_n <= 1'b0;
					o_upper_addr_status    <= UPPER_ZERO;
					o_upper_byte_en_n      <= 1'b1;
				end
				else if (!low_power)
				begin
					o_muxed_addr_data_oe_n <= 1'b1;
					o_upper_addr_status    <= i_use_prefetch ? UPPER_HALT_NIB : UPPER_ZERO;
				end
				else
					o_muxed_addr_data_oe_n <= 1'b1;
			end
			else
				o_muxed_addr_data_oe_n <= 1'b1;
		end
	end

	// ****************************************************************
	// Vector capture and status
	// ****************************************************************
	// Only the low lanes hold the vector; cascade bits are not ours.
	// Capture waits two cycles so it lines up with the synchronised bus
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cap_pipe_reg   <= 2'h0;
			o_vector       <= 8'h00;
			o_vector_valid <= 1'b0;
		end
		else
		begin
			cap_pipe_reg   <= {cap_pipe_reg[0], !is_halt_reg && second_reg
				&& (state_reg == IHBC_ST_T3 || state_reg == IHBC_ST_TW) && ready_ok};
			o_vector_valid <= cap_pipe_reg[1];
			if (cap_pipe_reg[1])
				o_vector <= bus_s2_reg[7:0];
		end
	end

	// Halt and exit status toward the core
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_halted     <= 1'b0;
			o_away_grant <= 1'b0;
			o_reload_req <= 1'b0;
		end
		else
		begin
			o_halted     <= (state_reg == IHBC_ST_HALT) || (state_reg == IHBC_ST_AWAY);
			o_away_grant <= (state_reg == IHBC_ST_AWAY);
			o_reload_req <= (state_reg == IHBC_ST_HALT) && irq_s2_reg;
		end
	end

endmodule // ihbc_bus_cycles

// [design/ihbc_pkg.sv]
package ihbc_pkg;

	// ****************************************************************
	// Cycle status encodings (active-low status lines)
	// ****************************************************************
	localparam logic [2:0] CST_INTACK  = 3'h0;
	localparam logic [2:0] CST_HALT    = 3'h3;
	localparam logic [2:0] CST_PASSIVE = 3'h7;

	// ****************************************************************
	// Fixed pin values
	// ****************************************************************
	localparam logic [3:0]  UPPER_HALT_NIB  = 4'h8;
	localparam logic [3:0]  UPPER_ZERO      = 4'h0;
	localparam logic [15:0] PCB_BASE_ZERO   = 16'h0000;
	localparam int unsigned IDLE_T_STATES   = 4;
	localparam logic [2:0]  IDLE_CNT_W_MAX  = 3'h4;

	// ****************************************************************
	// Bus sequencer states
	// ****************************************************************
	typedef enum logic [3:0] {
		IHBC_ST_IDLE = 4'h0,
		IHBC_ST_T1   = 4'h1,
		IHBC_ST_T2   = 4'h3,
		IHBC_ST_T3   = 4'h2,
		IHBC_ST_TW   = 4'h6,
		IHBC_ST_T4   = 4'h7,
		IHBC_ST_HALT = 4'h5,
		IHBC_ST_AWAY = 4'h4
	} ihbc_state_t;

endpackage

// [verif/ihbc_ctrl_model.sv]
`timescale 1ns/1ps
module ihbc_ctrl_model (
	input wire logic        i_sys_clk,
	input wire logic        i_arst_n,
	input wire logic        i_strobe_n,
	input wire logic        i_latch,
	input wire logic        i_atomic_n,
	input wire logic        i_cs_block,
	input wire logic [1:0]  i_mode,
	input wire logic [7:0]  i_vec,
	input wire logic [2:0]  i_casc,
	output logic            o_ready,
	output logic            o_dec_sel,
	output logic [15:0]     o_data
);
	// ****************************************************************
	// External vector controller
	// ****************************************************************
	logic [3:0]  low_cnt;
	logic        prev_n;
	logic        second;
	logic [15:0] pat;
	// Strobe length, pair position and a restless idle pattern
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			low_cnt <= 4'h0;
			prev_n <= 1'b1;
			second <= 1'b0;
			pat <= 16'h1234;
		end
		else
		begin
			low_cnt <= i_strobe_n ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
			prev_n <= i_strobe_n;
			second <= second ^ (i_strobe_n && !prev_n);
			pat <= {pat[14:0], ~pat[15]};
		end
	end
	// ready ends cycle
	// Slow ready drops with the strobe so a stale level cannot end the next cycle
	assign o_ready = (i_mode == 2'h0) || (i_mode == 2'h1 && low_cnt >= 4'h3 && !i_strobe_n);
	assign o_dec_sel = i_latch && i_atomic_n && !i_cs_block;
	assign o_data = (!i_strobe_n && second) ? {i_casc, pat[4:0], i_vec} : pat;
endmodule // ihbc_ctrl_model

// [verif/ihbc_props.sv]
`timescale 1ns/1ps
module ihbc_chk
	import ihbc_pkg::*;
(
	input wire logic        i_sys_clk,
	input wire logic        i_arst_n,
	input wire logic        i_cascade_mode,
	input wire logic [15:0] i_periph_ctrl_block_base,
	input wire logic        i_idle_mode,
	input wire logic        i_powerdown_mode,
	input wire logic [15:0] o_muxed_addr_data,
	input wire logic        o_muxed_addr_data_oe_n,
	input wire logic [3:0]  o_upper_addr_status,
	input wire logic        o_addr_latch,
	input wire logic        o_irq_ack_strobe_n,
	input wire logic        o_rd_n,
	input wire logic        o_wr_n,
	input wire logic        o_xcvr_output_en_n,
	input wire logic        o_xcvr_direction,
	input wire logic        o_refresh_flag_n,
	input wire logic [2:0]  o_cycle_status,
	input wire logic        o_atomic_n,
	input wire logic        o_chip_sel_block,
	input wire logic        o_halted,
	input wire logic        o_away_grant
);
	// ****************************************************************
	// Bus cycle properties
	// ****************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	// Ready bypass and power mode qualifiers
	wire byp = i_cascade_mode && (i_periph_ctrl_block_base == PCB_BASE_ZERO);
	wire pm = i_idle_mode || i_powerdown_mode;
	property p_ack_start;
		$fell(o_atomic_n) |-> o_addr_latch && o_cycle_status == CST_INTACK && !o_xcvr_direction;
	endproperty
	a_ack_start: assert property (p_ack_start) else $error("ack start wrong");
	property p_strobe;
		!o_irq_ack_strobe_n |-> !o_atomic_n && o_rd_n && o_wr_n && !o_xcvr_output_en_n;
	endproperty
	a_strobe: assert property (p_strobe) else $error("ack strobe wrong");
	property p_two;
		$fell(o_irq_ack_strobe_n) |=> !o_irq_ack_strobe_n;
	endproperty
	a_two: assert property (p_two) else $error("strobe too short");
	property p_byp;
		$fell(o_irq_ack_strobe_n) && byp |=> !o_irq_ack_strobe_n ##1 o_irq_ack_strobe_n;
	endproperty
	a_byp: assert property (p_byp) else $error("bypass waited");
	property p_pair;
		$rose(o_irq_ack_strobe_n) && !o_atomic_n |-> ##[1:2] (o_addr_latch || o_atomic_n);
	endproperty
	a_pair: assert property (p_pair) else $error("gap in pair");
	property p_float;
		o_addr_latch && !o_atomic_n |-> o_muxed_addr_data_oe_n;
	endproperty
	a_float: assert property (p_float) else $error("address driven");
	property p_halt_ctl;
		o_halted |-> o_rd_n && o_wr_n && o_xcvr_output_en_n && o_xcvr_direction
			&& o_refresh_flag_n && o_cycle_status == CST_PASSIVE && o_chip_sel_block;
	endproperty
	a_halt_ctl: assert property (p_halt_ctl) else $error("halt controls");
	property p_plain;
		o_halted && !pm |-> o_muxed_addr_data_oe_n;
	endproperty
	a_plain: assert property (p_plain) else $error("plain halt drives");
	property p_quiet;
		(o_halted && !o_away_grant && pm)[*6] |-> !o_muxed_addr_data_oe_n
			&& o_muxed_addr_data == 16'h0000
			&& o_upper_addr_status == UPPER_ZERO;
	endproperty
	a_quiet: assert property (p_quiet) else $error("not quiet");
	property p_pd;
		o_halted && i_powerdown_mode |=> !o_away_grant;
	endproperty
	a_pd: assert property (p_pd) else $error("powerdown released");
	property p_ret;
		$fell(o_away_grant) |-> (!o_addr_latch && o_cycle_status == CST_PASSIVE)[*3];
	endproperty
	a_ret: assert property (p_ret) else $error("halt cycle rerun");
	// Main scenarios
	c_byp: cover property (byp && $fell(o_irq_ack_strobe_n));
	c_ret: cover property ($fell(o_away_grant));
	c_pd: cover property (o_halted && i_powerdown_mode);
endmodule // ihbc_chk

bind ihbc_bus_cycles ihbc_chk u_chk (
	.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_cascade_mode(i_cascade_mode),
	.i_periph_ctrl_block_base(i_periph_ctrl_block_base), .i_idle_mode(i_idle_mode),
	.i_powerdown_mode(i_powerdown_mode), .o_muxed_addr_data(o_muxed_addr_data),
	.o_muxed_addr_data_oe_n(o_muxed_addr_data_oe_n), .o_upper_addr_status(o_upper_addr_status),
	.o_addr_latch(o_addr_latch), .o_irq_ack_strobe_n(o_irq_ack_strobe_n), .o_rd_n(o_rd_n),
	.o_wr_n(o_wr_n), .o_xcvr_output_en_n(o_xcvr_output_en_n),
	.o_xcvr_direction(o_xcvr_direction), .o_refresh_flag_n(o_refresh_flag_n),
	.o_cycle_status(o_cycle_status), .o_atomic_n(o_atomic_n),
	.o_chip_sel_block(o_chip_sel_block), .o_halted(o_halted), .o_away_grant(o_away_grant)
);

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
	import ihbc_pkg::*;
	// ****************************************************************
	// Stimulus and checks
	// ****************************************************************
	logic clk, rst_n, ack, hreq, aw, upf, casc, idle, pd, irq, done, rdy;
	logic lat, stb_n, rd_n, wr_n, xen_n, xdir, rf_n, atom_n, csb, vv, hlted, away, rld;
	logic ad_oe_n, ube_n, dsel;
	logic [15:0] base, wval, bus_in, ad, pdat;
	logic [3:0]  ua;
	logic [2:0]  st, req;
	logic [1:0]  mode;
	logic [7:0]  vec, vout;
	int fail_count, checks;
	// Bus wire: the device wins while it drives
	assign bus_in = ad_oe_n ? pdat : ad;
	ihbc_bus_cycles u_dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_ack_req(ack),
		.i_halt_instr(hreq), .i_after_write(aw), .i_use_prefetch(upf),
		.i_prefetch_upper(4'h9), .i_write_value(wval), .i_cascade_mode(casc),
		.i_periph_ctrl_block_base(base), .i_idle_mode(idle), .i_powerdown_mode(pd),
		.i_ready(rdy), .i_irq(irq), .i_hold_req(req[0]), .i_dma_req(req[1]),
		.i_refresh_req(req[2]), .i_away_done(done), .i_muxed_addr_data(bus_in),
		.o_muxed_addr_data(ad), .o_muxed_addr_data_oe_n(ad_oe_n), .o_upper_addr_status(ua),
		.o_upper_byte_en_n(ube_n), .o_addr_latch(lat), .o_irq_ack_strobe_n(stb_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_xcvr_output_en_n(xen_n), .o_xcvr_direction(xdir),
		.o_refresh_flag_n(rf_n), .o_cycle_status(st), .o_atomic_n(atom_n),
		.o_chip_sel_block(csb), .o_vector_valid(vv), .o_vector(vout), .o_halted(hlted),
		.o_away_grant(away), .o_reload_req(rld));
	ihbc_ctrl_model u_ctl (.i_sys_clk(clk), .i_arst_n(rst_n), .i_strobe_n(stb_n),
		.i_latch(lat), .i_atomic_n(atom_n), .i_cs_block(csb),
		.i_mode(mode), .i_vec(vec), .i_casc(3'h5), .o_ready(rdy), .o_dec_sel(dsel),
		.o_data(pdat));
	// Free-running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, exp, got);
		end
	endtask
	// Acknowledge pair: mode 0 prompt, 1 slow, 2 never ready
	task automatic t_ack(input logic [1:0] m, input logic b, input logic [7:0] v);
		int ns, nl;
		ns = 0;
		nl = 0;
		mode = m;
		casc = b;
		base = b ? 16'h0000 : 16'h0400;
		vec = v;
		ack = 1'b1;
		@(negedge clk);
		ack = 1'b0;
		for (int i = 0; i < 60 && !vv; i++)
		begin
			@(negedge clk);
			ns += int'(!stb_n);
			nl += int'(lat);
			if (lat)
				chk("decode", dsel, 1'b0);
		end
		chk("vector", {vv, 7'h0, vout}, {8'h80, v});
		chk("latches", 16'(nl), 16'h2);
		chk("strobe cycles", 16'(ns > 4 ? 5 : ns), (m == 0 || b) ? 16'h4 : 16'h5);
		repeat (4) @(negedge clk);
	endtask
	// Halt, temporary exit on rq, quiet check, interrupt exit
	task automatic t_halt(input logic p, input logic id, input logic w, input logic [2:0] rq);
		int nl;
		pd = p;
		idle = id;
		aw = w;
		upf = w;
		wval = 16'hA5C3;
		hreq = 1'b1;
		@(negedge clk);
		hreq = 1'b0;
		for (int i = 0; i < 20 && !hlted; i++)
		begin
			@(negedge clk);
			if (lat)
				chk("halt t1", w ? ad : {15'h0, ad_oe_n}, w ? wval : 16'h1);
			if (lat && w)
				chk("halt t1 top", {12'h0, ua}, 16'h9);
			if (lat)
				chk("decode halt", dsel, 1'b0);
		end
		chk("halted", hlted, 1'b1);
		req = rq;
		for (int i = 0; i < 12 && !away; i++)
			@(negedge clk);
		chk("away", away, !p);
		// Drop the request first; the synchroniser needs edges to clear it
		req = 3'h0;
		repeat (3) @(negedge clk);
		done = 1'b1;
		nl = 0;
		for (int i = 0; i < 20 && away; i++)
		begin
			@(negedge clk);
			nl += int'(lat);
		end
		done = 1'b0;
		chk("return latch", 16'(nl), 16'h0);
		chk("back in halt", {away, hlted}, 16'h1);
		repeat (8) @(negedge clk);
		chk("halt float", ad_oe_n, !(p || id));
		chk("byte high", ube_n, 1'b1);
		chk("halt top", {12'h0, ua}, (p || id || !w) ? 16'h0 : 16'h8);
		if (p || id)
			chk("quiet bus", ad, 16'h0);
		irq = 1'b1;
		for (int i = 0; i < 10 && !rld; i++)
			@(negedge clk);
		chk("reload", rld, 1'b1);
		irq = 1'b0;
		repeat (4) @(negedge clk);
		chk("resumed", hlted, 1'b0);
	endtask
	task automatic report_and_stop;
		if (fail_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, far beyond the expected run
	initial
	begin
		#100000;
		fail_count++;
		report_and_stop;
	end
	// Main sequence, reset held from time zero
	initial
	begin
		{rst_n, ack, hreq, aw, upf, casc, idle, pd, irq, done} = 10'h0;
		{base, wval, mode, vec, req} = {16'h0400, 16'h0, 2'h0, 8'h0, 3'h0};
		fail_count = 0;
		checks = 0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_ack(2'h0, 1'b0, 8'h5A);
		t_ack(2'h1, 1'b0, 8'hC3);
		t_ack(2'h2, 1'b1, 8'h81);
		t_halt(1'b0, 1'b0, 1'b1, 3'h1);
		t_halt(1'b0, 1'b1, 1'b0, 3'h2);
		t_halt(1'b0, 1'b0, 1'b0, 3'h4);
		t_halt(1'b1, 1'b0, 1'b0, 3'h7);
		report_and_stop;
	end
endmodule // tb
